// *** core/dbc_core.sv ***
// Bus cycle address and control signalling of a four-channel DMA engine
// Operation
// - Idle: low address lines are inputs selecting a control register.
// - Active service: low address lines output transfer address bits 3..0.
// - Wide mode and 16-bit channel: address bit zero held low throughout.
// - Upper nibble address driven only during service, otherwise released.
// - Hold request on unmasked channel request or software request.
// - Hold request looped to grant gives exactly one hold-wait state.
// - Grant output of serviced channel marks its ownership of the cycle; no grant in memory-to-memory mode.
// - Grant polarity programmable; reset leaves grants active low.
// - Address drive enable high during transfers to enable upper latch.
// - Block mode: upper strobe only when upper byte changes.
// - Upper address strobe timed from clock falling edge.
// - Memory read strobe on read transfers and memory-to-memory read half.
// - Memory write strobe on write transfers and memory-to-memory write half.
// - Width/latch enable released whenever wide mode is off.
// - Wide mode address-update state: width output low 16-bit, high 8-bit.
// - Memory-to-memory read half: width output latches upper data byte.
// - Memory-to-memory write half: width output returns held byte to bus.
// - Upper eight address bits placed on data lines in the address-update state.
// - I/O read strobe driven during write-direction transfers.
// - I/O write strobe driven during read-direction transfers.
`timescale 1ns/1ps
`include "dbc_map.svh"
module dbc_core #(
   parameter int CHANNELS = 4
) (
   input  wire logic                                   ref_clk,
   input  wire logic                                   rst_b,
   input  wire logic [CHANNELS-1:0]                    channel_request_in,
   input  wire logic [CHANNELS-1:0]                    channel_mask,
   input  wire logic [CHANNELS-1:0]                    soft_request,
   input  wire logic [CHANNELS-1:0]                    width_select,
   input  wire logic                                   wide_mode_en,
   input  wire logic                                   grant_active_high,
   input  wire logic                                   mem_to_mem_en,
   input  wire dbc_pkg::dbc_chan_cfg_type [CHANNELS-1:0] chan_cfg,
   input  wire logic [`DBC_ADDR_W-1:0]                 start_addr,
   input  wire logic [`DBC_ADDR_W-1:0]                 dest_addr,
   input  wire logic [`DBC_ADDR_W-1:0]                 start_count,
   input  wire logic                                   hold_grant,
   input  wire logic [3:0]                             low_address_lines_in,
   output logic [3:0]                                  low_address_lines_out,
   output logic                                        low_address_lines_oe,
   output logic [3:0]                                  idle_reg_select,
   output logic [3:0]                                  upper_nibble_address_out,
   output logic                                        upper_nibble_address_oe,
   input  wire logic [7:0]                             data_lines_in,
   output logic [7:0]                                  data_lines_out,
   output logic                                        data_lines_oe,
   output logic                                        hold_request,
   output logic [CHANNELS-1:0]                         channel_grant_out,
   output logic                                        address_drive_enable,
   output logic                                        upper_address_strobe,
   output dbc_pkg::dbc_strobe_type                     strobe_out,
   output logic                                        strobe_oe,
   output logic                                        width_latch_enable_out,
   output logic                                        width_latch_enable_oe
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Fixed priority, channel zero first
   function automatic logic [1:0] pick_chan(input logic [CHANNELS-1:0] req);
      logic [1:0] idx;
      idx = 2'd0;
      for (int i = CHANNELS - 1; i >= 0; i--)
      begin
         if (req[i])
            idx = 2'(i);
      end
      return idx;
   endfunction : pick_chan
   function automatic logic [7:0] upper_byte(input logic [`DBC_ADDR_W-1:0] a);
      return a[`DBC_UPBYTE_MSB:`DBC_UPBYTE_LSB];
   endfunction : upper_byte
   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   dbc_pkg::dbc_state_type   state_reg, state_next;
   logic                     half_reg, half_next;
   logic                     fresh_reg, fresh_next;
   logic [1:0]               chan_reg, chan_next;
   logic [`DBC_ADDR_W-1:0]   src_reg, src_next;
   logic [`DBC_ADDR_W-1:0]   dst_reg, dst_next;
   logic [`DBC_ADDR_W-1:0]   cnt_reg, cnt_next;
   logic [7:0]               upper_reg, upper_next;
   logic [7:0]               temp_reg, temp_next;
   logic [CHANNELS-1:0]      pending;
   logic                     wide_ch;
   logic [`DBC_ADDR_W-1:0]   step;
   logic [`DBC_ADDR_W-1:0]   src_inc;
   logic [`DBC_ADDR_W-1:0]   dst_inc;
   assign pending = (channel_request_in & ~channel_mask) | soft_request;
   assign wide_ch = wide_mode_en & width_select[chan_reg];
   assign step    = wide_ch ? `DBC_STEP_WORD : `DBC_STEP_BYTE;
   assign src_inc = src_reg + step;
   assign dst_inc = dst_reg + step;
   // Next state of the service sequence
   always_comb
   begin
      state_next = state_reg;
      half_next  = half_reg;
      fresh_next = fresh_reg;
      chan_next  = chan_reg;
      src_next   = src_reg;
      dst_next   = dst_reg;
      cnt_next   = cnt_reg;
      upper_next = upper_reg;
      temp_next  = temp_reg;
      unique case (state_reg)
         dbc_pkg::ST_IDLE:
            if (|pending)
            begin
               chan_next  = pick_chan(pending);
               src_next   = start_addr;
               dst_next   = dest_addr;
               cnt_next   = start_count;
               half_next  = 1'b0;
               fresh_next = 1'b1;
               state_next = dbc_pkg::ST_HOLD;
            end
         // No transfer until the host grants the bus
         dbc_pkg::ST_HOLD:
            if (hold_grant)
               state_next = dbc_pkg::ST_UPD;
         dbc_pkg::ST_UPD:
         begin
            upper_next = upper_byte(half_reg ? dst_reg : src_reg);
            fresh_next = 1'b0;
            state_next = dbc_pkg::ST_S2;
         end
         dbc_pkg::ST_S2:
            state_next = dbc_pkg::ST_S3;
         dbc_pkg::ST_S3:
         begin
            if (mem_to_mem_en && !half_reg)
               temp_next = data_lines_in;
            state_next = dbc_pkg::ST_S4;
         end
         dbc_pkg::ST_S4:
         begin
            // Skip address update while upper byte is unchanged
            if (mem_to_mem_en && !half_reg)
            begin
               half_next  = 1'b1;
               state_next = (upper_byte(dst_reg) != upper_reg) ? dbc_pkg::ST_UPD : dbc_pkg::ST_S2;
            end
            else
            begin
               half_next = 1'b0;
               src_next  = src_inc;
               dst_next  = dst_inc;
               cnt_next  = cnt_reg - `DBC_STEP_BYTE;
               if (cnt_reg == `DBC_ADDR_RST || !chan_cfg[chan_reg].block)
                  state_next = dbc_pkg::ST_IDLE;
               else if (upper_byte(src_inc) != upper_reg)
                  state_next = dbc_pkg::ST_UPD;
               else
                  state_next = dbc_pkg::ST_S2;
            end
         end
         default:
            state_next = dbc_pkg::ST_IDLE;
      endcase
   end
   // Sequencer registers
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= dbc_pkg::ST_IDLE;
         half_reg  <= 1'b0;
         fresh_reg <= 1'b0;
         chan_reg  <= 2'd0;
         src_reg   <= `DBC_ADDR_RST;
         dst_reg   <= `DBC_ADDR_RST;
         cnt_reg   <= `DBC_ADDR_RST;
         upper_reg <= `DBC_BYTE_RST;
         temp_reg  <= `DBC_BYTE_RST;
      end
      else
      begin
         state_reg <= state_next;
         half_reg  <= half_next;
         fresh_reg <= fresh_next;
         chan_reg  <= chan_next;
         src_reg   <= src_next;
         dst_reg   <= dst_next;
         cnt_reg   <= cnt_next;
         upper_reg <= upper_next;
         temp_reg  <= temp_next;
      end
   end
   // ----------------------------------------
   // Pin outputs
   // ----------------------------------------
   // Outputs follow the next state so every pin comes straight from a flop
   logic                   svc_n, wide_n, m2m_rd_n, m2m_wr_n;
   logic [`DBC_ADDR_W-1:0] addr_n;
   logic [3:0]             low_out_next, sel_next, nib_next, grant_next;
   logic [7:0]             data_next;
   logic                   low_oe_next, data_oe_next, hold_next, aen_next;
   logic                   wle_next, wle_oe_next, stb_oe_next;
   dbc_pkg::dbc_strobe_type strobe_next;
   always_comb
   begin
      svc_n    = (state_next != dbc_pkg::ST_IDLE) && (state_next != dbc_pkg::ST_HOLD);
      wide_n   = wide_mode_en & width_select[chan_next];
      m2m_rd_n = mem_to_mem_en & !half_next;
      m2m_wr_n = mem_to_mem_en & half_next;
      addr_n   = half_next ? dst_next : src_next;
      // Capture register select while the bus belongs to the host
      sel_next = svc_n ? idle_reg_select : low_address_lines_in;
      // Low address drive, even word addresses
      low_oe_next  = svc_n;
      low_out_next = {addr_n[`DBC_LOW_MSB:1], addr_n[0] & ~wide_n};
      nib_next = svc_n ? addr_n[`DBC_UPNIB_MSB:`DBC_UPNIB_LSB] : `DBC_NIB_RST;
      // Upper address byte on data lines in update state
      data_oe_next = svc_n && ((state_next == dbc_pkg::ST_UPD) || m2m_wr_n);
      data_next    = (state_next == dbc_pkg::ST_UPD) ? upper_byte(addr_n) : temp_next;
      // Hold request held across the whole service
      hold_next = (state_next != dbc_pkg::ST_IDLE);
      grant_next = (svc_n && !mem_to_mem_en) ? (4'h1 << chan_next) : 4'h0;
      grant_next = grant_active_high ? grant_next : ~grant_next;
      // Drive enable, held for service, dropped at idle
      aen_next = svc_n;
      // Memory read, memory write, I/O read, I/O write
      stb_oe_next = svc_n;
      strobe_next = `DBC_STROBE_RST;
      if ((state_next == dbc_pkg::ST_S2) || (state_next == dbc_pkg::ST_S3))
      begin
         strobe_next.mem_rd_b = !(m2m_rd_n || (!mem_to_mem_en && chan_cfg[chan_next].dir == dbc_pkg::DIR_READ));
         strobe_next.io_rd_b  = !(!mem_to_mem_en && chan_cfg[chan_next].dir == dbc_pkg::DIR_WRITE);
      end
      if (state_next == dbc_pkg::ST_S3)
      begin
         strobe_next.mem_wr_b = !(m2m_wr_n || (!mem_to_mem_en && chan_cfg[chan_next].dir == dbc_pkg::DIR_WRITE));
         strobe_next.io_wr_b  = !(!mem_to_mem_en && chan_cfg[chan_next].dir == dbc_pkg::DIR_READ);
      end
      // Released unless wide mode is on
      wle_oe_next = wide_mode_en && svc_n;
      // Width code, latch upper byte, return it
      if (state_next == dbc_pkg::ST_UPD)
         wle_next = ~wide_n;
      else if (m2m_rd_n)
         wle_next = (state_next == dbc_pkg::ST_S3);
      else
         wle_next = m2m_wr_n;
   end
   // Pin registers; reset leaves every driver released
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         low_address_lines_out    <= `DBC_NIB_RST;
         low_address_lines_oe     <= 1'b0;
         idle_reg_select          <= `DBC_NIB_RST;
         upper_nibble_address_out <= `DBC_NIB_RST;
         upper_nibble_address_oe  <= 1'b0;
         data_lines_out           <= `DBC_BYTE_RST;
         data_lines_oe            <= 1'b0;
         hold_request             <= 1'b0;
         channel_grant_out        <= `DBC_GRANT_RST;
         address_drive_enable     <= 1'b0;
         strobe_out               <= `DBC_STROBE_RST;
         strobe_oe                <= 1'b0;
         width_latch_enable_out   <= 1'b1;
         width_latch_enable_oe    <= 1'b0;
      end
      else
      begin
         low_address_lines_out    <= low_out_next;
         low_address_lines_oe     <= low_oe_next;
         idle_reg_select          <= sel_next;
         upper_nibble_address_out <= nib_next;
         upper_nibble_address_oe  <= svc_n;
         data_lines_out           <= data_next;
         data_lines_oe            <= data_oe_next;
         hold_request             <= hold_next;
         channel_grant_out        <= grant_next;
         address_drive_enable     <= aen_next;
         strobe_out               <= strobe_next;
         strobe_oe                <= stb_oe_next;
         width_latch_enable_out   <= wle_next;
         width_latch_enable_oe    <= wle_oe_next;
      end
   end
   // ----------------------------------------
   // Upper address strobe
   // ----------------------------------------
   // Falling-edge timing gives the latch half a cycle of setup
   logic stb_next;
   assign stb_next = (state_reg == dbc_pkg::ST_UPD);
   always_ff @(negedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         upper_address_strobe <= 1'b0;
      else
         upper_address_strobe <= stb_next;
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_hold_on_request:
      assert property ((state_reg == dbc_pkg::ST_IDLE) && (|pending) |=> hold_request)
      else $error("hold request not raised for pending channel");
   a_one_hold_wait:
      assert property ((state_reg == dbc_pkg::ST_HOLD) && hold_grant |=> state_reg == dbc_pkg::ST_UPD)
      else $error("hold-wait not left on grant");
   a_even_word_addr:
      assert property (low_address_lines_oe && wide_mode_en && width_select[chan_reg] |-> !low_address_lines_out[0])
      else $error("odd address on 16-bit channel");
   a_upper_nib_idle:
      assert property (state_reg == dbc_pkg::ST_IDLE |=> !upper_nibble_address_oe && !address_drive_enable)
      else $error("upper address driven while idle");
   a_width_released:
      assert property (!wide_mode_en |=> !width_latch_enable_oe)
      else $error("width output driven outside wide mode");
   a_width_code:
      assert property (wide_mode_en && state_reg == dbc_pkg::ST_UPD |-> width_latch_enable_out == ~wide_ch)
      else $error("wrong width code in address update");
   a_grant_idle_level:
      assert property (!hold_request |-> channel_grant_out == {4{~$past(grant_active_high)}})
      else $error("grant not inactive while idle");
   a_strobe_falling:
      assert property (@(negedge ref_clk) disable iff (!rst_b)
         $rose(upper_address_strobe) |-> $past(state_reg) == dbc_pkg::ST_UPD)
      else $error("upper strobe outside address update");
   a_read_pair:
      assert property (strobe_oe && !mem_to_mem_en && !strobe_out.mem_rd_b |-> !strobe_out.io_rd_b == 1'b0)
      else $error("memory read paired with I/O read");
endmodule : dbc_core

// *** inc/dbc_map.svh ***
// Constants for the DMA bus cycle signalling block
`ifndef DBC_MAP_SVH
`define DBC_MAP_SVH

// ----------------------------------------
// Address field positions
// ----------------------------------------
`define DBC_ADDR_W        16
`define DBC_LOW_MSB       3
`define DBC_UPNIB_MSB     7
`define DBC_UPNIB_LSB     4
`define DBC_UPBYTE_MSB    15
`define DBC_UPBYTE_LSB    8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DBC_GRANT_RST     4'hF
`define DBC_STROBE_RST    4'hF
`define DBC_BYTE_RST      8'h00
`define DBC_ADDR_RST      16'h0000
`define DBC_NIB_RST       4'h0

// ----------------------------------------
// Address steps
// ----------------------------------------
`define DBC_STEP_BYTE     16'h0001
`define DBC_STEP_WORD     16'h0002

`endif

// *** inc/dbc_pkg.sv ***
// Types shared by the DMA bus cycle signalling block
package dbc_pkg;

   // ----------------------------------------
   // Service states
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_HOLD = 3'b001,
      ST_UPD  = 3'b010,
      ST_S2   = 3'b011,
      ST_S3   = 3'b100,
      ST_S4   = 3'b101
   } dbc_state_type;

   // ----------------------------------------
   // Transfer direction per channel
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      DIR_VERIFY = 2'b00,
      DIR_WRITE  = 2'b01,
      DIR_READ   = 2'b10
   } dbc_dir_type;

   // Per-channel configuration
   typedef struct packed
   {
      dbc_dir_type dir;
      logic        block;
   } dbc_chan_cfg_type;

   // Active-low bus strobes
   typedef struct packed
   {
      logic mem_rd_b;
      logic mem_wr_b;
      logic io_rd_b;
      logic io_wr_b;
   } dbc_strobe_type;

endpackage : dbc_pkg

// *** tb/dbc_host_model.sv ***
// Host bus and memory model facing the DMA bus cycle signalling block
`timescale 1ns/1ps

module dbc_host_model #(
   parameter int         SLOW_CYC = 3,
   parameter logic [7:0] MEM_BYTE = 8'h5A
) (
   input  wire logic                    ref_clk,
   input  wire logic                    rst_b,
   input  wire logic                    slow,
   input  wire logic                    hold_request,
   input  wire dbc_pkg::dbc_strobe_type strobe_out,
   input  wire logic                    strobe_oe,
   input  wire logic [7:0]              data_lines_out,
   input  wire logic                    data_lines_oe,
   output logic                         hold_grant,
   output logic [7:0]                   data_lines_in
);
   logic [3:0] wait_reg, wait_next;
   logic [7:0] last_reg, last_next;
   logic       mem_drive;

   // Count cycles of pending hold; saturates so a long stall never wraps
   always_comb
   begin
      wait_next = hold_request ? ((wait_reg == 4'hF) ? wait_reg : wait_reg + 4'h1) : 4'h0;
      last_next = data_lines_in;
   end

   // State registers
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wait_reg <= 4'h0;
         last_reg <= 8'h00;
      end
      else
      begin
         wait_reg <= wait_next;
         last_reg <= last_next;
      end
   end

   // Grant after SLOW_CYC cycles of hold when slow, or looped back when prompt
   assign hold_grant = hold_request && (!slow || (wait_reg >= 4'(SLOW_CYC)));

   // Memory answers a read; a released bus shows the inverse, never a stale value
   assign mem_drive     = strobe_oe && !strobe_out.mem_rd_b && !data_lines_oe;
   assign data_lines_in = data_lines_oe ? data_lines_out : (mem_drive ? MEM_BYTE : ~last_reg);

endmodule : dbc_host_model

// *** tb/tb.sv ***
// Self-checking bench for the DMA bus cycle signalling block
`timescale 1ns/1ps
`include "dbc_map.svh"

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb;
   logic ref_clk = 1'b0, rst_b = 1'b0, slow = 1'b0;
   logic [3:0] channel_request_in = 4'h0, channel_mask = 4'h0, soft_request = 4'h0, width_select = 4'h0;
   logic wide_mode_en = 1'b0, grant_active_high = 1'b0, mem_to_mem_en = 1'b0;
   dbc_pkg::dbc_chan_cfg_type [3:0] chan_cfg = '0;
   logic [15:0] start_addr = 16'h0000, dest_addr = 16'h0000, start_count = 16'h0000;
   logic [3:0] low_address_lines_in = 4'h0;
   logic hold_grant, low_address_lines_oe, upper_nibble_address_oe, data_lines_oe, hold_request;
   logic address_drive_enable, upper_address_strobe, strobe_oe, width_latch_enable_out, width_latch_enable_oe;
   logic [3:0] low_address_lines_out, idle_reg_select, upper_nibble_address_out, channel_grant_out;
   logic [7:0] data_lines_in, data_lines_out;
   dbc_pkg::dbc_strobe_type strobe_out, strb_and, prev_strb;
   // Snapshot of the first service cycle plus running tallies
   logic [3:0] s_low, s_nib, s_grant;
   logic [7:0] s_data, held;
   logic s_nib_oe, s_wle, s_wle_oe, s_stb_early, a0_hi, prev_stb;
   int n_wait, n_stb, n_units, errors = 0, samples_checked = 0, cyc = 0;

   dbc_core #(.CHANNELS(4)) dbc_core_i (
      .ref_clk(ref_clk), .rst_b(rst_b), .channel_request_in(channel_request_in), .channel_mask(channel_mask),
      .soft_request(soft_request), .width_select(width_select), .wide_mode_en(wide_mode_en),
      .grant_active_high(grant_active_high), .mem_to_mem_en(mem_to_mem_en), .chan_cfg(chan_cfg),
      .start_addr(start_addr), .dest_addr(dest_addr), .start_count(start_count), .hold_grant(hold_grant),
      .low_address_lines_in(low_address_lines_in), .low_address_lines_out(low_address_lines_out),
      .low_address_lines_oe(low_address_lines_oe), .idle_reg_select(idle_reg_select),
      .upper_nibble_address_out(upper_nibble_address_out), .upper_nibble_address_oe(upper_nibble_address_oe),
      .data_lines_in(data_lines_in), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
      .hold_request(hold_request), .channel_grant_out(channel_grant_out),
      .address_drive_enable(address_drive_enable), .upper_address_strobe(upper_address_strobe),
      .strobe_out(strobe_out), .strobe_oe(strobe_oe), .width_latch_enable_out(width_latch_enable_out),
      .width_latch_enable_oe(width_latch_enable_oe));

   dbc_host_model #(.SLOW_CYC(3), .MEM_BYTE(8'h5A)) dbc_host_model_i (
      .ref_clk(ref_clk), .rst_b(rst_b), .slow(slow), .hold_request(hold_request), .strobe_out(strobe_out),
      .strobe_oe(strobe_oe), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
      .hold_grant(hold_grant), .data_lines_in(data_lines_in));

   // ----------------------------------------
   // Clock, timeout and verdict
   // ----------------------------------------
   always #10 ref_clk = ~ref_clk;

   // A stuck service would otherwise hang the run
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         errors++;
         final_report();
      end
   end

   task automatic final_report;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : tick

   // ----------------------------------------
   // One service: request, watch every cycle until idle
   // ----------------------------------------
   task automatic serve(input int ch, input logic sft, input dbc_pkg::dbc_dir_type dir,
                        input logic blk, input logic [15:0] adr);
      logic seen, done;
      seen = 1'b0;
      done = 1'b0;
      n_wait = 0; n_stb = 0; n_units = 0; a0_hi = 1'b0; held = 8'h00; prev_stb = 1'b0;
      strb_and = 4'hF;
      prev_strb = 4'hF;
      chan_cfg[ch].dir = dir;
      chan_cfg[ch].block = blk;
      start_addr = adr;
      start_count = blk ? 16'h0001 : 16'h0000;
      if (sft)
         soft_request[ch] = 1'b1;
      else
         channel_request_in[ch] = 1'b1;
      for (int n = 0; n < 80 && !done; n++)
      begin
         @(posedge ref_clk);
         #2;
         // Request held until address drive enable answers it
         if (address_drive_enable)
         begin
            channel_request_in = 4'h0;
            soft_request = 4'h0;
            if (!seen)
               s_stb_early = upper_address_strobe;
         end
         #13;
         if (hold_request && !address_drive_enable && !seen)
            n_wait++;
         if (address_drive_enable && !seen)
         begin
            seen = 1'b1;
            s_low = low_address_lines_out; s_nib = upper_nibble_address_out; s_nib_oe = upper_nibble_address_oe;
            s_data = data_lines_out; s_grant = channel_grant_out;
            s_wle = width_latch_enable_out; s_wle_oe = width_latch_enable_oe;
         end
         if (upper_address_strobe && !prev_stb)
            n_stb++;
         prev_stb = upper_address_strobe;
         if (address_drive_enable)
         begin
            strb_and = strb_and & strobe_out;
            if (low_address_lines_oe)
               a0_hi = a0_hi | low_address_lines_out[0];
            if (!strobe_out.mem_wr_b && data_lines_oe)
               held = data_lines_out;
            if ((&prev_strb) && !(&strobe_out))
               n_units++;
         end
         prev_strb = strobe_out;
         done = seen && !address_drive_enable;
      end
      `CHK({hold_request, low_address_lines_oe, upper_nibble_address_oe, data_lines_oe, strobe_oe}, 5'h00)
      `CHK(width_latch_enable_oe, 1'b0)
      tick(1);
   endtask : serve

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge ref_clk);
      `CHK(channel_grant_out, 4'hF)
      `CHK({hold_request, address_drive_enable, strobe_oe, strobe_out}, 7'h0F)
      #2;
      rst_b = 1'b1;
      low_address_lines_in = 4'hA;
      tick(2);
      `CHK(idle_reg_select, 4'hA)
      // Masked request must be ignored
      channel_mask = 4'b0100;
      channel_request_in = 4'b0100;
      tick(4);
      `CHK(hold_request, 1'b0)
      channel_request_in = 4'h0;
      tick(1);
      // Write direction, looped grant, active-low grants
      serve(1, 1'b0, dbc_pkg::DIR_WRITE, 1'b0, 16'hABC5);
      `CHK(s_low, 4'h5)
      `CHK({s_nib_oe, s_nib}, 5'h1C)
      `CHK(s_data, 8'hAB)
      `CHK(s_grant, 4'hD)
      `CHK(n_wait, 1)
      `CHK({s_stb_early, 4'(n_stb)}, 5'h01)
      `CHK(strb_and, 4'b1001)
      `CHK(s_wle_oe, 1'b0)
      `CHK(n_units, 1)
      // Software request on a masked channel, slow grant, active-high grants
      channel_mask = 4'b1000;
      grant_active_high = 1'b1;
      slow = 1'b1;
      serve(3, 1'b1, dbc_pkg::DIR_READ, 1'b0, 16'h0010);
      `CHK(s_grant, 4'h8)
      `CHK(strb_and, 4'b0110)
      `CHK(n_wait > 2, 1'b1)
      slow = 1'b0;
      grant_active_high = 1'b0;
      // Block mode: upper byte kept, then crossing a byte boundary
      serve(0, 1'b0, dbc_pkg::DIR_READ, 1'b1, 16'h12FE);
      `CHK({4'(n_units), 4'(n_stb)}, 8'h21)
      serve(0, 1'b0, dbc_pkg::DIR_READ, 1'b1, 16'h12FF);
      `CHK({4'(n_units), 4'(n_stb)}, 8'h22)
      // Wide mode: 16-bit channel, then 8-bit channel
      wide_mode_en = 1'b1;
      width_select = 4'b0001;
      serve(0, 1'b0, dbc_pkg::DIR_WRITE, 1'b0, 16'h3457);
      `CHK({a0_hi, s_low}, 5'h06)
      `CHK({s_wle_oe, s_wle}, 2'b10)
      serve(1, 1'b0, dbc_pkg::DIR_WRITE, 1'b0, 16'h3457);
      `CHK({s_wle_oe, s_wle, s_low}, 6'h37)
      // Memory-to-memory, 16-bit
      mem_to_mem_en = 1'b1;
      width_select = 4'hF;
      dest_addr = 16'h4000;
      serve(0, 1'b0, dbc_pkg::DIR_READ, 1'b0, 16'h2000);
      `CHK(strb_and[3:2], 2'b00)
      `CHK(held, 8'h5A)
      `CHK({s_wle_oe, s_grant}, 5'h1F)
      final_report();
   end

endmodule : tb
